//--- core/ocmaw_pkg.sv
// Package for the on-chip memory access window: register offsets,
// field positions, reset values, carrier struct and state type.
// Assumes an 8-bit register-access port driven by a two-wire bus slave.

`default_nettype none

package ocmaw_pkg;

    // Register offsets on the bus register pointer
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h8b; // memory_address_high
    localparam logic [7:0] OFS_ADDR_LOW = 8'h8c; // memory_address_low
    localparam logic [7:0] OFS_NV_PORT = 8'h8d; // nonvolatile_read_port
    localparam logic [7:0] OFS_SRAM_PORT = 8'h8e; // sram_data_port

    // Field layout
    localparam int HIGH_FIELD_MSB = 3; // start address bits 11:8 live here
    localparam int HIGH_FIELD_LSB = 0;
    localparam int ARRAY_ADDR_MSB = 8; // both arrays use pointer bits 8:0
    localparam int ARRAY_DEPTH = 512; // bytes in the shadow SRAM

    // Reset values
    localparam logic [3:0] RST_ADDR_HIGH = 4'h0;
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [7:0] RST_PORT_DATA = 8'h00; // also the refused-read value
    localparam logic [11:0] RST_WORK_PTR = 12'h000;

    // Response buffer depth
    localparam logic [1:0] RSP_BUF_DEPTH = 2'h2;

    // One register access from the bus slave
    typedef struct packed {
        logic [7:0] addr; // bus register pointer
        logic write; // 1 = write, 0 = read
        logic [7:0] wdata; // byte from the bus
    } ocmaw_req_type;

    // Non-volatile array fetch sequencer
    typedef enum logic [0:0] {
        OCMAW_IDLE,
        OCMAW_NV_WAIT
    } ocmaw_state_type;

endpackage

`default_nettype wire

//--- core/ocmaw_access_window.sv
// Indirect byte access from the bus register map into the on-chip
// non-volatile array (read only) and its shadow SRAM (read/write).
// Assumes the bus slave presents one register access at a time, pulses
// txn_end_i at every stop or repeated start, and that the external
// array returns nv_rdata_i in the cycle in which nv_rd_o is high.

`timescale 1ns/10ps
`default_nettype none

module ocmaw_access_window
    import ocmaw_pkg::*;
(
    input wire logic mclk_i, // 250 MHz clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic clk_en_i, // Freezes all state when low
    input wire logic txn_end_i, // Bus transaction finished, pulse
    input wire logic req_valid_i, // Register access offered
    output logic req_ready_o, // Register access may be taken
    input wire ocmaw_req_type req_i, // Register access contents
    output logic rsp_valid_o, // Read byte available
    input wire logic rsp_ready_i, // Bus slave takes the read byte
    output logic [7:0] rsp_data_o, // Read byte, from buffer flops
    output logic ptr_hold_o, // Bus pointer must not auto-increment
    input wire logic prog_busy_i, // program_in_progress_flag
    input wire logic load_busy_i, // array_load_to_registers running
    output logic nv_rd_o, // Non-volatile array read strobe
    output logic [8:0] nv_addr_o, // Non-volatile array byte address
    input wire logic [7:0] nv_rdata_i, // Non-volatile array byte
    output logic [3:0] addr_high_o, // memory_address_high field
    output logic [7:0] addr_low_o // memory_address_low contents
);

    // Array index from a 12-bit pointer; only bits 8:0 reach the arrays
    function automatic logic [8:0] array_index(input logic [11:0] ptr);
        array_index = ptr[ARRAY_ADDR_MSB:0];
    endfunction

    // Registers
    logic [3:0] addr_high_r; // Start address bits 11:8
    logic [7:0] addr_low_r; // Start address bits 7:0
    logic [11:0] work_ptr_r; // Working pointer of the stream
    logic nv_active_r; // Non-volatile stream open
    logic ram_active_r; // SRAM stream open
    logic [8:0] nv_addr_r; // Address presented to the array
    ocmaw_state_type state_r; // Fetch sequencer
    ocmaw_state_type state_nxt;
    logic [7:0] sram_mem [0:ARRAY_DEPTH-1]; // Shadow SRAM, no reset

    // Response buffer, two entries
    logic [7:0] buf_r [0:1]; // Buffered read bytes
    logic buf_wr_r; // Next slot to fill
    logic buf_rd_r; // Next slot to drain
    logic [1:0] buf_cnt_r; // Bytes held

    // Decode of the offered access
    wire logic hit_high = req_i.addr == OFS_ADDR_HIGH;
    wire logic hit_low = req_i.addr == OFS_ADDR_LOW;
    wire logic hit_nv = req_i.addr == OFS_NV_PORT;
    wire logic hit_ram = req_i.addr == OFS_SRAM_PORT;

    // Load stall and sequencer gate acceptance; a full buffer does too,
    // so a read is never taken without a slot to hold its answer
    wire logic buf_full = buf_cnt_r == RSP_BUF_DEPTH;
    wire logic buf_empty = buf_cnt_r == 2'h0;
    assign req_ready_o = !load_busy_i && (state_r == OCMAW_IDLE) &&
        !buf_full;

    wire logic take = clk_en_i && req_valid_i && req_ready_o;
    wire logic is_rd = !req_i.write;

    // Non-volatile port: reads only, refused while programming
    wire logic nv_refused = hit_nv && prog_busy_i;
    wire logic nv_step = take && hit_nv && is_rd && !prog_busy_i;
    // SRAM port: reads and writes both advance the stream
    wire logic ram_step = take && hit_ram;
    wire logic ram_wr = ram_step && req_i.write;

    // Start address assembled from both address registers
    wire logic [11:0] start_ptr = {addr_high_r, addr_low_r};

    // First access copies the start address, later ones increment
    wire logic stream_open = hit_nv ? nv_active_r : ram_active_r;
    wire logic [11:0] ptr_inc = work_ptr_r + 12'h001;
    wire logic [11:0] access_ptr = stream_open ? ptr_inc : start_ptr;
    wire logic [8:0] access_idx = array_index(access_ptr);

    // Read answer for everything except an accepted array fetch
    wire logic [7:0] imm_data =
        hit_high ? {4'h0, addr_high_r} :
        hit_low ? addr_low_r :
        hit_ram ? sram_mem[access_idx] :
        RST_PORT_DATA; // Refused or unmapped reads answer zero

    // Buffer fill: immediate reads, or the array byte one cycle later
    wire logic nv_return = clk_en_i && (state_r == OCMAW_NV_WAIT);
    wire logic push = (take && is_rd && !nv_step) || nv_return;
    wire logic [7:0] push_data = nv_return ? nv_rdata_i : imm_data;
    wire logic pop = clk_en_i && rsp_ready_i && !buf_empty;

    assign rsp_valid_o = !buf_empty;
    assign rsp_data_o = buf_r[buf_rd_r];
    assign ptr_hold_o = nv_active_r || ram_active_r;
    assign nv_rd_o = state_r == OCMAW_NV_WAIT;
    assign nv_addr_o = nv_addr_r;
    assign addr_high_o = addr_high_r;
    assign addr_low_o = addr_low_r;

    // Sequencer: one wait cycle while the array answers
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            OCMAW_IDLE:
            begin
                if (nv_step)
                begin
                    state_nxt = OCMAW_NV_WAIT;
                end
            end
            OCMAW_NV_WAIT:
            begin
                state_nxt = OCMAW_IDLE; // Byte captured this cycle
            end
            default:
            begin
                state_nxt = OCMAW_IDLE;
            end
        endcase
    end

    // Address registers; only the low nibble of the high one exists
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            addr_high_r <= RST_ADDR_HIGH;
            addr_low_r <= RST_ADDR_LOW;
        end
        else if (take && req_i.write)
        begin
            if (hit_high)
            begin
                addr_high_r <= req_i.wdata[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
            end
            if (hit_low)
            begin
                addr_low_r <= req_i.wdata;
            end
        end
    end

    // Stream state; transaction end wins over a same-cycle access, but is ignored while clk_en_i is low
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            nv_active_r <= 1'b0;
            ram_active_r <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (txn_end_i)
            begin
                nv_active_r <= 1'b0;
                ram_active_r <= 1'b0;
            end
            else
            begin
                if (nv_step)
                begin
                    nv_active_r <= 1'b1;
                end
                if (ram_step)
                begin
                    ram_active_r <= 1'b1;
                end
            end
        end
    end

    // Working pointer and array address
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            work_ptr_r <= RST_WORK_PTR;
            nv_addr_r <= 9'h000;
            state_r <= OCMAW_IDLE;
        end
        else if (clk_en_i)
        begin
            state_r <= state_nxt;
            if (nv_step || ram_step)
            begin
                work_ptr_r <= access_ptr;
            end
            if (nv_step)
            begin
                nv_addr_r <= access_idx;
            end
        end
    end

    // SRAM write port; contents are not reset, as in a real macro
    always_ff @(posedge mclk_i)
    begin
        if (ram_wr)
        begin
            sram_mem[access_idx] <= req_i.wdata;
        end
    end

    // Response buffer slots
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            buf_r[0] <= RST_PORT_DATA;
            buf_r[1] <= RST_PORT_DATA;
        end
        else if (push)
        begin
            buf_r[buf_wr_r] <= push_data;
        end
    end

    // Response buffer pointers and fill count
    always_ff @(posedge mclk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            buf_wr_r <= 1'b0;
            buf_rd_r <= 1'b0;
            buf_cnt_r <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                buf_wr_r <= !buf_wr_r;
            end
            if (pop)
            begin
                buf_rd_r <= !buf_rd_r;
            end
            if (push && !pop)
            begin
                buf_cnt_r <= buf_cnt_r + 2'h1;
            end
            else if (pop && !push)
            begin
                buf_cnt_r <= buf_cnt_r - 2'h1;
            end
        end
    end

    // High register write keeps only the address nibble
    a_high_nibble_only: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        take && hit_high && req_i.write |=>
            addr_high_o == $past(req_i.wdata[3:0]))
        else $error("high address register took wrong bits");

    // First data-port access copies both address registers
    a_ptr_copy_start: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        (nv_step || ram_step) && !ptr_hold_o |=>
            work_ptr_r == {$past(addr_high_r), $past(addr_low_r)})
        else $error("working pointer not loaded from start address");

    // First array read fetches the start address, strobe next cycle
    a_nv_first_addr: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        nv_step && !nv_active_r |=>
            nv_rd_o && nv_addr_o == $past(start_ptr[8:0]))
        else $error("first array read not at start address");

    // Later array reads step the address by one
    a_nv_next_addr: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        nv_step && nv_active_r |=>
            nv_addr_o == $past(work_ptr_r[8:0]) + 9'h001)
        else $error("array read address did not advance by one");

    // An array access locks the pointer until transaction end
    a_nv_lock_held: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        nv_step && !txn_end_i ##1 (!txn_end_i || !clk_en_i) [*2] |->
            ptr_hold_o)
        else $error("pointer lock lost inside transaction");

    // Transaction end drops every stream
    a_txn_end_unlock: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        clk_en_i && txn_end_i |=> !ptr_hold_o)
        else $error("stream survived transaction end");

    // Programming busy refuses the array and answers zero
    a_nv_refused: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        take && nv_refused && is_rd |=> !nv_rd_o && rsp_valid_o)
        else $error("array accessed while programming busy");

    // No register access is taken during an array load
    a_load_stall: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        load_busy_i |-> !req_ready_o)
        else $error("access accepted during array load");

    // An SRAM write lands at the computed address
    a_ram_write: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        ram_wr |=> sram_mem[$past(access_idx)] == $past(req_i.wdata))
        else $error("SRAM write byte not stored");

    // SRAM access opens the SRAM stream lock
    a_ram_lock: assert property (
        @(posedge mclk_i) disable iff (!resetn_i)
        ram_step && !txn_end_i |=> ptr_hold_o)
        else $error("SRAM access did not lock the pointer");

endmodule

`default_nettype wire

//--- test/ocmaw_nv_model.sv
// Behavioural model of the non-volatile array behind the access window.
// Assumes the window strobes nv_rd_i and takes the byte in that cycle.
`timescale 1ns/10ps
`default_nettype none
module ocmaw_nv_model
(
    input wire logic mclk_i, // Window clock
    input wire logic nv_rd_i, // Read strobe from the window
    input wire logic [8:0] nv_addr_i, // Array byte address
    output logic [7:0] nv_rdata_o // Array byte back to the window
);
    logic [7:0] last_r = 8'h00; // Last byte handed out
    // Content depends on bit 8 too, so a dropped address bit shows
    wire [7:0] byte_w = nv_addr_i[7:0] ^ {7'h00, nv_addr_i[8]} ^ 8'h5a;
    // Remember the byte so the idle bus can show its inverse
    always @(posedge mclk_i)
        if (nv_rd_i)
            last_r <= byte_w;
    // Outside the strobe the lines carry no stale copy of the data
    assign nv_rdata_o = nv_rd_i ? byte_w : ~last_r;
endmodule
`default_nettype wire

//--- test/tb_onchip_memory_access_window.sv
// Self-checking bench for the memory access window.
// Assumes the array model answers strobes in the same cycle.
`timescale 1ns/10ps
`default_nettype none
module tb_onchip_memory_access_window
    import ocmaw_pkg::*;
;
    logic mclk_i, resetn_i, clk_en_i, txn_end_i, req_valid_i; // Drives
    logic rsp_ready_i, prog_busy_i, load_busy_i; // Drives
    ocmaw_req_type req_i; // Access contents
    logic req_ready_o, rsp_valid_o, ptr_hold_o, nv_rd_o; // Observed
    logic [7:0] rsp_data_o, nv_rdata_i, addr_low_o; // Observed bytes
    logic [8:0] nv_addr_o; // Array address
    logic [3:0] addr_high_o; // High field
    int errors, compares; // Tallies
    logic [7:0] exp_q[$]; // Expected read bytes in order

    ocmaw_access_window dut_u (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .clk_en_i(clk_en_i), .txn_end_i(txn_end_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o),
        .ptr_hold_o(ptr_hold_o), .prog_busy_i(prog_busy_i),
        .load_busy_i(load_busy_i), .nv_rd_o(nv_rd_o),
        .nv_addr_o(nv_addr_o), .nv_rdata_i(nv_rdata_i),
        .addr_high_o(addr_high_o), .addr_low_o(addr_low_o));
    ocmaw_nv_model nv_u (.mclk_i(mclk_i), .nv_rd_i(nv_rd_o),
        .nv_addr_i(nv_addr_o), .nv_rdata_o(nv_rdata_i));

    // Clock at 4 ns period
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    // Expected array byte, worked out independently of the window
    function automatic logic [7:0] nv_exp(input logic [8:0] a);
        return a[7:0] ^ {7'h00, a[8]} ^ 8'h5a;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Offer one access at a rising edge; return at the edge that takes it
    task automatic issue(input logic [7:0] a, input logic w,
        input logic [7:0] d);
        int n;
        n = 0;
        req_i <= '{addr: a, write: w, wdata: d};
        req_valid_i <= 1'b1;
        @(negedge mclk_i);
        while (req_ready_o !== 1'b1 && n < 50)
        begin
            @(negedge mclk_i);
            n++;
        end
        // A request that is never taken counts against the run
        if (n >= 50)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, req_ready_o,
                1'b1);
        end
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        issue(a, 1'b0, 8'h00);
    endtask

    task automatic idle();
        req_valid_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Stop or repeated start, then let answers drain
    task automatic txn_end();
        req_valid_i <= 1'b0;
        txn_end_i <= 1'b1;
        @(posedge mclk_i);
        txn_end_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
    endtask

    // Every popped byte must match the oldest expectation
    always @(negedge mclk_i)
        if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1)
        begin
            if (exp_q.size() == 0)
            begin
                // A byte nobody asked for is a mismatch, even if unknown
                compares++;
                errors++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, rsp_data_o,
                    8'h00);
            end
            else
                chk(rsp_data_o, exp_q.pop_front());
        end

    task automatic t_reset();
        chk({7'h00, rsp_valid_o}, 8'h00);
        chk({7'h00, ptr_hold_o}, 8'h00);
        rd(OFS_ADDR_HIGH, 8'h00);
        rd(OFS_ADDR_LOW, 8'h00);
        txn_end();
    endtask

    task automatic t_addr();
        issue(OFS_ADDR_HIGH, 1'b1, 8'hfa);
        issue(OFS_ADDR_LOW, 1'b1, 8'hfe);
        rd(OFS_ADDR_HIGH, 8'h0a);
        rd(OFS_ADDR_LOW, 8'hfe);
        txn_end();
        chk({4'h0, addr_high_o}, 8'h0a);
        chk(addr_low_o, 8'hfe);
    endtask

    // Start 0xafe: array bits 8:0 run 0x0fe, 0x0ff, 0x100
    task automatic t_nv();
        rd(OFS_NV_PORT, nv_exp(9'h0fe));
        rd(OFS_NV_PORT, nv_exp(9'h0ff));
        rd(OFS_NV_PORT, nv_exp(9'h100));
        idle();
        chk({7'h00, ptr_hold_o}, 8'h01);
        txn_end();
        chk({7'h00, ptr_hold_o}, 8'h00);
        rd(OFS_NV_PORT, nv_exp(9'h0fe));
        txn_end();
    endtask

    task automatic t_busy();
        prog_busy_i <= 1'b1;
        rd(OFS_NV_PORT, RST_PORT_DATA);
        idle();
        chk({7'h00, ptr_hold_o}, 8'h00);
        prog_busy_i <= 1'b0;
        txn_end();
    endtask

    task automatic t_sram();
        issue(OFS_SRAM_PORT, 1'b1, 8'h11);
        issue(OFS_SRAM_PORT, 1'b1, 8'h22);
        issue(OFS_SRAM_PORT, 1'b1, 8'h33);
        idle();
        chk({7'h00, ptr_hold_o}, 8'h01);
        // A transaction end while frozen must not drop the lock
        clk_en_i <= 1'b0;
        txn_end_i <= 1'b1;
        @(posedge mclk_i);
        clk_en_i <= 1'b1;
        txn_end_i <= 1'b0;
        @(posedge mclk_i);
        chk({7'h00, ptr_hold_o}, 8'h01);
        txn_end();
        chk({7'h00, ptr_hold_o}, 8'h00);
        rd(OFS_SRAM_PORT, 8'h11);
        rd(OFS_SRAM_PORT, 8'h22);
        rd(OFS_SRAM_PORT, 8'h33);
        txn_end();
    endtask

    // Unmapped read, array-port write and a load in progress
    task automatic t_refuse();
        rd(8'h90, 8'h00);
        issue(OFS_NV_PORT, 1'b1, 8'h77);
        rd(OFS_ADDR_LOW, 8'hfe);
        chk({7'h00, ptr_hold_o}, 8'h00);
        txn_end();
        load_busy_i <= 1'b1;
        @(negedge mclk_i);
        chk({7'h00, req_ready_o}, 8'h00);
        @(posedge mclk_i);
        load_busy_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Two bytes fill the buffer while the bus slave stalls
    task automatic t_buffer();
        rsp_ready_i <= 1'b0;
        @(posedge mclk_i);
        rd(OFS_ADDR_HIGH, 8'h0a);
        rd(OFS_ADDR_LOW, 8'hfe);
        idle();
        @(negedge mclk_i);
        chk({6'h00, req_ready_o, rsp_valid_o}, 8'h01);
        @(posedge mclk_i);
        rsp_ready_i <= 1'b1;
        txn_end();
        chk({7'h00, rsp_valid_o}, 8'h00);
    endtask

    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run is under a hundred cycles
    initial
    begin
        #20000;
        errors++;
        give_verdict();
    end

    initial
    begin
        errors = 0;
        compares = 0;
        resetn_i = 1'b0;
        clk_en_i = 1'b1;
        txn_end_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        rsp_ready_i = 1'b1;
        prog_busy_i = 1'b0;
        load_busy_i = 1'b0;
        repeat (8) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        t_reset();
        t_addr();
        t_nv();
        t_busy();
        t_sram();
        t_refuse();
        t_buffer();
        chk(exp_q.size(), 8'h00);
        give_verdict();
    end
endmodule
`default_nettype wire
